// File: inc/udc_image_if.sv
`timescale 1ns/1ps
interface udc_image_if;
	import udc_pkg::*;
	udc_flags_t image;
	logic loaded;
	modport src (output image, output loaded);
	modport dst (input image, input loaded);
endinterface

// File: inc/udc_pkg.sv
package udc_pkg;
	localparam int UDC_ADDR_W = 12;
	localparam logic [11:0] UDC_CFG_OFFSET = 12'h080;
	localparam int UDC_LPM_BIT = 30;
	localparam int UDC_SUSP_BIT = 29;
	localparam int UDC_SPEED_HI = 15;
	localparam int UDC_SPEED_LO = 13;
	localparam int UDC_TXR_BIT = 10;
	localparam int UDC_RXR_BIT = 9;
	localparam int UDC_BIR_BIT = 6;
	localparam int UDC_BCE_BIT = 5;
	localparam int UDC_SWAP_BIT = 4;
	localparam int UDC_WAKE_BIT = 2;
	localparam int UDC_PWR_BIT = 1;
	localparam int UDC_SBP_BIT = 0;
	localparam logic [2:0] UDC_SPEED_HIGH = 3'h0;
	localparam logic [2:0] UDC_SPEED_FULL = 3'h1;
	localparam logic [2:0] UDC_SPEED_RST = 3'h0;
	localparam logic UDC_LPM_DFLT = 1'b1;
	localparam logic UDC_SUSP_DFLT = 1'b1;
	localparam logic UDC_SWAP_DFLT = 1'b0;
	localparam logic UDC_WAKE_DFLT = 1'b1;
	localparam logic UDC_PWR_DFLT = 1'b1;
	localparam logic UDC_BIR_RST = 1'b0;
	localparam logic UDC_BCE_RST = 1'b0;
	localparam logic UDC_SBP_RST = 1'b0;
	localparam int UDC_RESET_PULSE_CYCLES = 4;
	localparam int UDC_BURST_W = 8;
	typedef struct packed {
		logic lpm;
		logic susp;
		logic swap;
		logic wake;
		logic pwr;
	} udc_flags_t;
	localparam udc_flags_t UDC_FLAGS_DFLT = '{
		lpm: UDC_LPM_DFLT, susp: UDC_SUSP_DFLT, swap: UDC_SWAP_DFLT,
		wake: UDC_WAKE_DFLT, pwr: UDC_PWR_DFLT};
endpackage

// File: src/udc_config.sv
// Local design decision: the APB register port.
`timescale 1ns/1ps
// Contract
// - bit 30 turns link power management capability off at 0 and on at 1.
// - bit 29 clear keeps suspend off; set, valid conditions suspend the phy.
// - bits 15:13 pick connect speed, 000 high and 001 full, reset 000.
// - bit 10 written 1 resets bulk-in transmitter, self clears, resets 0.
// - bit 9 written 1 resets bulk-out receiver, self clears, resets 0.
// - in token on empty fifo gets zlp at bit 6 = 0, nak at 1, reset 0.
// - bit 5 set caps bulk-in bursts at the burst size, clear none, reset 0.
// - read-only bit 4 reports whether the usb data pins are swapped.
// - bit 2 advertises remote wakeup; device and function wakeup need it.
// - bit 1 reports bus powered at 0 and self powered at 1.
// - bulk-out sync loss stalls the pipe if bit 0 is 0, not if 1, reset 0.
// - suspend gate from eeprom, else otp, else 1; usb or lite reset reloads.
// - pin swap from eeprom, else otp, else 0; usb or lite reset reloads.
// - lpm, wakeup from eeprom, else otp, else 1; usb or lite reset reloads.
// - power method from eeprom else 1, no otp; usb or lite reset reloads.
module udc_config import udc_pkg::*; #(
	parameter int BURST_W = UDC_BURST_W,
	parameter int PULSE_CYCLES = UDC_RESET_PULSE_CYCLES
) (
	input wire logic I_CLOCK,
	input wire logic I_RST_N,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [UDC_ADDR_W-1:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic [3:0] I_PSTRB,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_IMAGE_LOAD,
	input wire logic I_EEPROM_PRESENT,
	input wire logic I_OTP_CONFIGURED,
	input wire logic [4:0] I_EEPROM_FLAGS,
	input wire logic [3:0] I_OTP_FLAGS,
	input wire logic I_USB_RESET,
	input wire logic I_LITE_RESET,
	input wire logic I_SUSPEND_COND,
	input wire logic I_IN_TOKEN,
	input wire logic I_RX_FIFO_EMPTY,
	input wire logic [BURST_W-1:0] I_BURST_SIZE,
	input wire logic I_SYNC_LOSS,
	output logic O_LPM_CAPABLE,
	output logic O_SUSPEND_N,
	output logic [2:0] O_CONNECT_SPEED,
	output logic O_TX_RESET,
	output logic O_RX_RESET,
	output logic O_IN_SEND_ZLP,
	output logic O_IN_SEND_NAK,
	output logic O_BURST_LIMIT_EN,
	output logic [BURST_W-1:0] O_BURST_LIMIT,
	output logic O_PIN_SWAP,
	output logic O_REMOTE_WAKE_OK,
	output logic O_SELF_POWERED,
	output logic O_BULK_OUT_STALL
);
	udc_image_if img ();

	logic lpm_q;
	logic susp_q;
	logic swap_q;
	logic wake_q;
	logic pwr_q;
	logic [2:0] speed_q;
	logic bir_q;
	logic bce_q;
	logic sbp_q;
	logic [31:0] prdata_q;
	logic slverr_q;
	logic suspend_n_q;
	logic zlp_q;
	logic nak_q;
	logic [BURST_W-1:0] burst_q;
	logic stall_q;
	logic tx_active;
	logic rx_active;

	wire addr_hit = (I_PADDR == UDC_CFG_OFFSET);
	wire setup = I_PSEL && !I_PENABLE;
	wire access = I_PSEL && I_PENABLE;
	wire wr_en = access && I_PWRITE && addr_hit;
	// byte lanes that carry control bits
	wire wr_b0 = wr_en && I_PSTRB[0];
	wire wr_b1 = wr_en && I_PSTRB[1];
	wire wr_b3 = wr_en && I_PSTRB[3];
	wire reload = img.loaded || I_USB_RESET || I_LITE_RESET;
	wire tx_start = wr_b1 && I_PWDATA[UDC_TXR_BIT];
	wire rx_start = wr_b1 && I_PWDATA[UDC_RXR_BIT];
	wire empty_in = I_IN_TOKEN && I_RX_FIFO_EMPTY;

	// reserved positions are hard zero here
	wire [31:0] rd_value = {1'b0, lpm_q, susp_q, 13'h0,
		speed_q, 2'h0, tx_active, rx_active, 2'h0, bir_q, bce_q,
		swap_q, 1'b0, wake_q, pwr_q, sbp_q};

	udc_image_sel u_image (
		.i_clock(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_load(I_IMAGE_LOAD),
		.i_eeprom_present(I_EEPROM_PRESENT),
		.i_otp_configured(I_OTP_CONFIGURED),
		.i_eeprom_flags(I_EEPROM_FLAGS),
		.i_otp_flags(I_OTP_FLAGS),
		.img(img.src)
	);

	udc_sc_pulse #(.CYCLES(PULSE_CYCLES)) u_tx_reset (
		.i_clock(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_start(tx_start),
		.o_active(tx_active)
	);

	udc_sc_pulse #(.CYCLES(PULSE_CYCLES)) u_rx_reset (
		.i_clock(I_CLOCK),
		.i_rst_n(I_RST_N),
		.i_start(rx_start),
		.o_active(rx_active)
	);

	// image-backed bits: a reload in the same cycle as a write wins,
	// since the reset sources mean the host view is being discarded
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			lpm_q <= UDC_LPM_DFLT;
			susp_q <= UDC_SUSP_DFLT;
			swap_q <= UDC_SWAP_DFLT;
			wake_q <= UDC_WAKE_DFLT;
			pwr_q <= UDC_PWR_DFLT;
		end else if (reload) begin
			lpm_q <= img.image.lpm;
			susp_q <= img.image.susp;
			swap_q <= img.image.swap;
			wake_q <= img.image.wake;
			pwr_q <= img.image.pwr;
		end else begin
			if (wr_b3) begin
				lpm_q <= I_PWDATA[UDC_LPM_BIT];
				susp_q <= I_PWDATA[UDC_SUSP_BIT];
			end
			if (wr_b0) begin
				wake_q <= I_PWDATA[UDC_WAKE_BIT];
				pwr_q <= I_PWDATA[UDC_PWR_BIT];
			end
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			speed_q <= UDC_SPEED_RST;
			bir_q <= UDC_BIR_RST;
			bce_q <= UDC_BCE_RST;
			sbp_q <= UDC_SBP_RST;
		end else begin
			if (wr_b1) begin
				speed_q <= I_PWDATA[UDC_SPEED_HI:UDC_SPEED_LO];
			end
			if (wr_b0) begin
				bir_q <= I_PWDATA[UDC_BIR_BIT];
				bce_q <= I_PWDATA[UDC_BCE_BIT];
				sbp_q <= I_PWDATA[UDC_SBP_BIT];
			end
		end
	end

	// read data is captured in setup so it is steady through access
	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			prdata_q <= 32'h0000_0000;
			slverr_q <= 1'b0;
		end else if (setup) begin
			prdata_q <= (addr_hit && !I_PWRITE) ? rd_value : 32'h0000_0000;
			slverr_q <= !addr_hit;
		end
	end

	always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			suspend_n_q <= 1'b1;
			zlp_q <= 1'b0;
			nak_q <= 1'b0;
			burst_q <= '0;
			stall_q <= 1'b0;
		end else begin
			suspend_n_q <= !(I_SUSPEND_COND && susp_q);
			zlp_q <= empty_in && !bir_q;
			nak_q <= empty_in && bir_q;
			burst_q <= bce_q ? I_BURST_SIZE : '0;
			stall_q <= I_SYNC_LOSS && !sbp_q;
		end
	end

	assign O_PRDATA = prdata_q;
	assign O_PREADY = 1'b1;
	assign O_PSLVERR = slverr_q && access;
	assign O_LPM_CAPABLE = lpm_q;
	assign O_SUSPEND_N = suspend_n_q;
	assign O_CONNECT_SPEED = speed_q;
	assign O_TX_RESET = tx_active;
	assign O_RX_RESET = rx_active;
	assign O_IN_SEND_ZLP = zlp_q;
	assign O_IN_SEND_NAK = nak_q;
	assign O_BURST_LIMIT_EN = bce_q;
	// zero on the limit port means unlimited bursts
	assign O_BURST_LIMIT = burst_q;
	assign O_PIN_SWAP = swap_q;
	assign O_REMOTE_WAKE_OK = wake_q;
	assign O_SELF_POWERED = pwr_q;
	assign O_BULK_OUT_STALL = stall_q;

	default clocking cb @(posedge I_CLOCK);
	endclocking
	default disable iff (!I_RST_N);

	chk_lpm_write: assert property (
		wr_b3 && !reload |=> O_LPM_CAPABLE == $past(I_PWDATA[UDC_LPM_BIT])
	) else $error("lpm capability did not follow write");

	chk_suspend_gate: assert property (
		!susp_q |=> O_SUSPEND_N
	) else $error("suspend signalled while gate clear");

	chk_suspend_active: assert property (
		susp_q && I_SUSPEND_COND |=> !O_SUSPEND_N
	) else $error("suspend not signalled while gated on");

	chk_speed_write: assert property (
		wr_b1 |=> O_CONNECT_SPEED == $past(I_PWDATA[15:13])
	) else $error("connect speed did not follow write");

	chk_tx_pulse: assert property (
		tx_start |=> O_TX_RESET [*4]
	) else $error("transmitter reset pulse too short");

	chk_rx_pulse: assert property (
		rx_start |=> O_RX_RESET [*4]
	) else $error("receiver reset pulse too short");

	chk_rx_clears: assert property (
		rx_start ##1 (!rx_start) [*4] |=> !O_RX_RESET
	) else $error("receiver reset did not self clear");

	chk_empty_resp: assert property (
		empty_in |=> (O_IN_SEND_NAK == $past(bir_q)) &&
			(O_IN_SEND_ZLP != $past(bir_q))
	) else $error("wrong answer to in token on empty fifo");

	chk_burst_off: assert property (
		!O_BURST_LIMIT_EN |=> O_BURST_LIMIT == '0
	) else $error("burst limited while disabled");

	chk_swap_ro: assert property (
		wr_en && !reload |=> $stable(O_PIN_SWAP)
	) else $error("pin swap changed by a write");

	chk_stall_policy: assert property (
		I_SYNC_LOSS |=> O_BULK_OUT_STALL == !$past(sbp_q)
	) else $error("stall policy on sync loss broken");

	chk_reload_image: assert property (
		(I_USB_RESET || I_LITE_RESET) |=>
			susp_q == $past(img.image.susp)
	) else $error("suspend gate not restored on reset");

	chk_reload_flags: assert property (
		reload |=> O_LPM_CAPABLE == $past(img.image.lpm) &&
			O_REMOTE_WAKE_OK == $past(img.image.wake) &&
			O_PIN_SWAP == $past(img.image.swap) &&
			O_SELF_POWERED == $past(img.image.pwr)
	) else $error("image flags not restored on reset");

	chk_reserved_zero: assert property (
		access && !I_PWRITE |-> (O_PRDATA & 32'h9fff_1988) == 32'h0000_0000
	) else $error("reserved bits read non-zero");

	chk_lpm_hold: assert property (
		!wr_b3 && !reload |=> $stable(O_LPM_CAPABLE)
	) else $error("lpm capability changed without a write");

	chk_susp_write: assert property (
		wr_b3 && !reload |=> susp_q == $past(I_PWDATA[UDC_SUSP_BIT])
	) else $error("suspend gate did not follow write");

	chk_speed_hold: assert property (
		!wr_b1 |=> $stable(O_CONNECT_SPEED)
	) else $error("connect speed changed without a write");

	chk_tx_clears: assert property (
		tx_start ##1 (!tx_start) [*4] |=> !O_TX_RESET
	) else $error("transmitter reset did not self clear");

	chk_tx_idle: assert property (
		!tx_start && !O_TX_RESET |=> !O_TX_RESET
	) else $error("transmitter reset without a write");

	chk_rx_idle: assert property (
		!rx_start && !O_RX_RESET |=> !O_RX_RESET
	) else $error("receiver reset without a write");

	chk_bir_write: assert property (
		wr_b0 |=> bir_q == $past(I_PWDATA[UDC_BIR_BIT])
	) else $error("empty response bit did not follow write");

	chk_empty_quiet: assert property (
		!empty_in |=> !O_IN_SEND_ZLP && !O_IN_SEND_NAK
	) else $error("in token answer without an empty fifo");

	chk_bce_write: assert property (
		wr_b0 |=> O_BURST_LIMIT_EN == $past(I_PWDATA[UDC_BCE_BIT])
	) else $error("burst limit enable did not follow write");

	chk_burst_on: assert property (
		O_BURST_LIMIT_EN |=> O_BURST_LIMIT == $past(I_BURST_SIZE)
	) else $error("burst limit not taken from burst size");

	chk_swap_hold: assert property (
		!reload |=> $stable(O_PIN_SWAP)
	) else $error("pin swap changed without a reload");

	chk_wake_write: assert property (
		wr_b0 && !reload |=> O_REMOTE_WAKE_OK == $past(I_PWDATA[UDC_WAKE_BIT])
	) else $error("remote wakeup did not follow write");

	chk_power_write: assert property (
		wr_b0 && !reload |=> O_SELF_POWERED == $past(I_PWDATA[UDC_PWR_BIT])
	) else $error("power method did not follow write");

	chk_sbp_write: assert property (
		wr_b0 |=> sbp_q == $past(I_PWDATA[UDC_SBP_BIT])
	) else $error("stall policy bit did not follow write");

	chk_stall_quiet: assert property (
		!I_SYNC_LOSS |=> !O_BULK_OUT_STALL
	) else $error("stall without a sync loss");

	cov_tx_reset: cover property (tx_start ##1 O_TX_RESET);
	cov_nak_answer: cover property (empty_in && bir_q ##1 O_IN_SEND_NAK);
	cov_lite_reload: cover property (I_LITE_RESET ##1 lpm_q);
	cov_unmapped: cover property (access && O_PSLVERR);
	cov_sync_stall: cover property (I_SYNC_LOSS && !sbp_q ##1 O_BULK_OUT_STALL);
endmodule // udc_config

// File: src/udc_image_sel.sv
`timescale 1ns/1ps
module udc_image_sel import udc_pkg::*; (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_load,
	input wire logic i_eeprom_present,
	input wire logic i_otp_configured,
	input wire logic [4:0] i_eeprom_flags,
	input wire logic [3:0] i_otp_flags,
	udc_image_if.src img
);
	udc_flags_t pick;
	udc_flags_t image_q;
	logic loaded_q;
	// eeprom first, then otp, then fixed; power method has no otp step
	function automatic logic first_src(input logic ee_on, input logic ee_val,
		input logic otp_on, input logic otp_val, input logic dflt);
		return ee_on ? ee_val : (otp_on ? otp_val : dflt);
	endfunction
	assign pick.lpm = first_src(i_eeprom_present, i_eeprom_flags[4],
		i_otp_configured, i_otp_flags[3], UDC_LPM_DFLT);
	assign pick.susp = first_src(i_eeprom_present, i_eeprom_flags[3],
		i_otp_configured, i_otp_flags[2], UDC_SUSP_DFLT);
	assign pick.swap = first_src(i_eeprom_present, i_eeprom_flags[2],
		i_otp_configured, i_otp_flags[1], UDC_SWAP_DFLT);
	assign pick.wake = first_src(i_eeprom_present, i_eeprom_flags[1],
		i_otp_configured, i_otp_flags[0], UDC_WAKE_DFLT);
	assign pick.pwr = first_src(i_eeprom_present, i_eeprom_flags[0],
		1'b0, 1'b0, UDC_PWR_DFLT);
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			image_q <= UDC_FLAGS_DFLT;
			loaded_q <= 1'b0;
		end else begin
			loaded_q <= i_load;
			if (i_load) begin
				image_q <= pick;
			end
		end
	end
	assign img.image = image_q;
	assign img.loaded = loaded_q;
endmodule // udc_image_sel

// File: src/udc_sc_pulse.sv
`timescale 1ns/1ps
module udc_sc_pulse #(
	parameter int CYCLES = 4
) (
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_start,
	output logic o_active
);
	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] LOAD = CW'(CYCLES);
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;
	logic active_q;
	// a second start while busy restarts the full length
	assign cnt_d = i_start ? LOAD :
		(cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cnt_q <= '0;
			active_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			active_q <= (cnt_d != '0);
		end
	end
	assign o_active = active_q;
endmodule // udc_sc_pulse

// File: testbench/udc_config_tb.sv
`timescale 1ns/1ps
module udc_config_tb;
	import udc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [UDC_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [3:0] pstrb = 4'hf;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic load = 1'b0, ee_present = 1'b0, otp_cfg = 1'b0;
	logic [4:0] ee_flags = '0;
	logic [3:0] otp_flags = '0;
	logic usb_rst = 1'b0, lite_rst = 1'b0, susp_cond = 1'b0;
	logic in_token = 1'b0, fifo_empty = 1'b1, sync_loss = 1'b0;
	logic [7:0] burst_size = 8'h5a;
	logic lpm, susp_n, tx_rst, rx_rst, zlp, nak, blim_en, swap, wake, selfp;
	logic stall;
	logic [2:0] speed;
	logic [7:0] blim;
	logic [31:0] rdata;
	logic slverr;
	int err_count = 0;
	int n_checks = 0;
	always #4 clk = ~clk;
	udc_config udc_config_inst (.I_CLOCK(clk), .I_RST_N(rst_n),
		.I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
		.I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
		.O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
		.I_IMAGE_LOAD(load), .I_EEPROM_PRESENT(ee_present),
		.I_OTP_CONFIGURED(otp_cfg), .I_EEPROM_FLAGS(ee_flags),
		.I_OTP_FLAGS(otp_flags), .I_USB_RESET(usb_rst),
		.I_LITE_RESET(lite_rst), .I_SUSPEND_COND(susp_cond),
		.I_IN_TOKEN(in_token), .I_RX_FIFO_EMPTY(fifo_empty),
		.I_BURST_SIZE(burst_size), .I_SYNC_LOSS(sync_loss),
		.O_LPM_CAPABLE(lpm), .O_SUSPEND_N(susp_n), .O_CONNECT_SPEED(speed),
		.O_TX_RESET(tx_rst), .O_RX_RESET(rx_rst), .O_IN_SEND_ZLP(zlp),
		.O_IN_SEND_NAK(nak), .O_BURST_LIMIT_EN(blim_en),
		.O_BURST_LIMIT(blim), .O_PIN_SWAP(swap), .O_REMOTE_WAKE_OK(wake),
		.O_SELF_POWERED(selfp), .O_BULK_OUT_STALL(stall));
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic check_word(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic check_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: %s got %b exp %b", $time, what, got, exp);
		end
	endtask
	// apb transfer; no wait states are assumed, pready is polled
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'b1;
		// a slave that never answers is left to the watchdog
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdata = prdata;
		slverr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] d);
		apb(1'b1, UDC_CFG_OFFSET, d, 4'hf);
	endtask
	task automatic rd_check(input logic [31:0] exp, input string what);
		apb(1'b0, UDC_CFG_OFFSET, 32'h0, 4'hf);
		check_word(rdata, exp, what);
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	// drive one-cycle event inputs, look at the answer the cycle after
	task automatic fire_events();
		@(posedge clk);
		in_token <= 1'b1;
		sync_loss <= 1'b1;
		@(posedge clk);
		in_token <= 1'b0;
		sync_loss <= 1'b0;
		@(negedge clk);
	endtask
	logic [31:0] cfg [2] = '{32'h0000_0000, 32'h0000_0061};
	logic [1:0] img_src [3] = '{2'b00, 2'b01, 2'b10};
	logic [31:0] img_exp [3] = '{32'h6000_0006, 32'h0000_0012, 32'h0000_0010};
	int hi_tx, hi_rx;
	initial begin
		#40000;
		err_count++;
		complete_run();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd_check(32'h6000_0006, "reset value");
		check_bit(susp_n, 1'b1, "suspend idle");
		check_word({29'h0, speed}, {29'h0, UDC_SPEED_HIGH}, "speed");
		$display("test reset done");
		wr(32'hffff_ffff);
		hi_tx = 0;
		hi_rx = 0;
		repeat (8) begin
			@(negedge clk);
			hi_tx += (tx_rst === 1'b1);
			hi_rx += (rx_rst === 1'b1);
		end
		check_word(hi_tx, 4, "tx reset length");
		check_word(hi_rx, 4, "rx reset length");
		rd_check(32'h6000_e067, "all ones");
		check_bit(lpm, 1'b1, "lpm on");
		check_bit(selfp, 1'b1, "self powered");
		check_bit(wake, 1'b1, "wake on");
		apb(1'b1, UDC_CFG_OFFSET, 32'h0, 4'h1);
		rd_check(32'h6000_e000, "lane0 only");
		wr(32'h0000_2000);
		rd_check(32'h0000_2000, "full speed");
		check_word({29'h0, speed}, {29'h0, UDC_SPEED_FULL}, "speed");
		check_bit(lpm, 1'b0, "lpm off");
		check_bit(wake, 1'b0, "wake off");
		check_bit(selfp, 1'b0, "bus powered");
		susp_cond <= 1'b1;
		settle(3);
		check_bit(susp_n, 1'b1, "suspend gated");
		wr(32'h2000_0000);
		settle(2);
		check_bit(susp_n, 1'b0, "suspend on");
		@(posedge clk);
		susp_cond <= 1'b0;
		$display("test fields done");
		for (int i = 0; i < 2; i++) begin
			wr(cfg[i]);
			settle(2);
			check_bit(blim_en, cfg[i][5], "burst enable");
			check_word({24'h0, blim}, cfg[i][5] ? {24'h0, burst_size} : 32'h0,
				"burst limit");
			fire_events();
			check_bit(zlp, ~cfg[i][6], "zlp");
			check_bit(nak, cfg[i][6], "nak");
			check_bit(stall, ~cfg[i][0], "stall");
		end
		$display("test events done");
		@(posedge clk);
		ee_flags <= 5'b11011;
		otp_flags <= 4'b0000;
		for (int i = 0; i < 3; i++) begin
			wr(32'h0);
			@(posedge clk);
			ee_present <= img_src[i][1];
			otp_cfg <= img_src[i][0];
			if (i == 1) otp_flags <= 4'b0010;
			if (i == 2) ee_flags <= 5'b00100;
			load <= 1'b1;
			@(posedge clk);
			load <= 1'b0;
			settle(4);
			rd_check(img_exp[i], "image load");
		end
		for (int i = 0; i < 2; i++) begin
			wr(32'h6000_0006);
			rd_check(32'h6000_0016, "sw over image");
			@(posedge clk);
			usb_rst <= (i == 0);
			lite_rst <= (i == 1);
			@(posedge clk);
			usb_rst <= 1'b0;
			lite_rst <= 1'b0;
			rd_check(32'h0000_0010, "image restore");
		end
		check_bit(swap, 1'b1, "pin swap");
		$display("test image done");
		apb(1'b1, 12'h084, 32'hffff_ffff, 4'hf);
		check_bit(slverr, 1'b1, "unmapped write");
		apb(1'b0, 12'h084, 32'h0, 4'hf);
		check_bit(slverr, 1'b1, "unmapped read");
		check_word(rdata, 32'h0, "unmapped data");
		rd_check(32'h0000_0010, "unchanged");
		check_bit(slverr, 1'b0, "mapped ok");
		$display("test unmapped done");
		complete_run();
	end
endmodule // udc_config_tb
